// [mfr_dev.sv]
// Fault response controller: device end of the link
`default_nettype none
`include "mfr_params.svh"
// Functional notes
// - Full disable forces every gate drive low
// - Supply undervoltage disables; latched only when restart_control=0
// - Latched faults clear on zero demand or run=0
// - Status/diag read clears latches when select=0
// - Host zeroes demand, then applies new demand
// - Host rewrites run 0 then 1; error clears run
// - Logic-supply faults hold host reset 10 ms
module mfr_dev
#(
	parameter int unsigned RST_HOLD_CYC = `MFR_RST_DELAY_MS * `MFR_CLK_MHZ * 1000
)
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	mfr_if.dev lnk,
	input wire logic supply_uv_i,
	input wire logic logic_regulator_uv_i,
	input wire logic gate_regulator_uv_i,
	input wire logic bootstrap_uv_i,
	input wire logic vds_ov_i,
	input wire logic lost_sync_i,
	input wire logic temp_warn_i,
	input wire logic overtemp_i,
	input wire logic serial_err_i,
	input wire logic system_err_i,
	output logic gates_low_o,
	output logic drive_enable_o,
	output logic logic_regulator_en_o,
	output logic restart_pulse_o,
	output logic [`MFR_DEM_W-1:0] demand_o
);
	logic [`MFR_DAT_W-1:0] ctrl_r;
	logic run_r;
	logic [`MFR_NLAT-1:0] lat_r;
	logic [`MFR_NLAT-1:0] lat_cond;
	logic sys_lat_r;
	logic ser_err_r;
	logic hold_r;
	logic ot_hold_r;
	logic rearm_r;
	logic [`MFR_RST_CNT_W-1:0] cnt_r;
	logic sync_prev_r;
	logic [`MFR_DAT_W-1:0] rdata_r;
	logic restart_control;
	logic dsr;
	logic ctrl_wr;
	logic rd_clr;
	logic demand_zero;
	logic clr_evt;
	logic rst_cond;
	logic cnt_end;
	logic disable_all;
	logic [`MFR_DAT_W-1:0] status_v;
	logic [`MFR_DAT_W-1:0] diag_v;

	assign restart_control = ctrl_r[`MFR_CTRL_RSC];
	assign dsr = ctrl_r[`MFR_CTRL_DSR];
	assign ctrl_wr = lnk.link_wr && (lnk.link_addr == `MFR_LA_CTRL);
	// Only a read of status or diagnostics clears, and only with select low
	assign rd_clr = lnk.link_rd && !dsr &&
		((lnk.link_addr == `MFR_LA_STATUS) || (lnk.link_addr == `MFR_LA_DIAG));
	assign demand_zero = (lnk.demand == '0);
	assign clr_evt = demand_zero || !run_r || rd_clr;
	assign rst_cond = logic_regulator_uv_i || overtemp_i;
	assign cnt_end = (cnt_r == `MFR_RST_CNT_W'(RST_HOLD_CYC - 1));

	// Control register; a system error drops run on its own
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			ctrl_r <= `MFR_CTRL_RST;
		else if (ctrl_wr)
			ctrl_r <= lnk.link_wdata;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			run_r <= 1'b0;
		else if (system_err_i)
			run_r <= 1'b0;
		else if (ctrl_wr)
			run_r <= lnk.link_wdata[`MFR_CTRL_RUN];
	end

	// Latched faults; restart_control=1 leaves supply UV and sync loss unlatched
	assign lat_cond[`MFR_ST_SUPPLY_UV] = supply_uv_i && !restart_control;
	assign lat_cond[`MFR_ST_BOOT_UV] = bootstrap_uv_i;
	assign lat_cond[`MFR_ST_VDS_OV] = vds_ov_i;
	assign lat_cond[`MFR_ST_LOST_SYNC] = lost_sync_i && !restart_control;

	genvar gi;
	generate
		for (gi = 0; gi < `MFR_NLAT; gi++)
		begin : g_lat
			// Set wins so a fault arriving with the clear is kept
			always_ff @(posedge sys_clk_i or negedge rstn_i)
			begin
				if (!rstn_i)
					lat_r[gi] <= 1'b0;
				else if (lat_cond[gi])
					lat_r[gi] <= 1'b1;
				else if (clr_evt)
					lat_r[gi] <= 1'b0;
			end
		end
	endgenerate

	// System error holds until run is written back to one
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			sys_lat_r <= 1'b0;
		else if (system_err_i)
			sys_lat_r <= 1'b1;
		else if (ctrl_wr && lnk.link_wdata[`MFR_CTRL_RUN])
			sys_lat_r <= 1'b0;
	end

	// Serial error is report only
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			ser_err_r <= 1'b0;
		else if (serial_err_i)
			ser_err_r <= 1'b1;
		else if (rd_clr)
			ser_err_r <= 1'b0;
	end

	// Host reset hold: restarts counting while the condition is present
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			hold_r <= 1'b0;
			cnt_r <= '0;
		end
		else if (rst_cond)
		begin
			hold_r <= 1'b1;
			cnt_r <= '0;
		end
		else if (hold_r)
		begin
			if (cnt_end)
			begin
				hold_r <= 1'b0;
				cnt_r <= '0;
			end
			else
				cnt_r <= cnt_r + 1'b1;
		end
	end

	// Overtemperature keeps the logic regulator off for the whole hold
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			ot_hold_r <= 1'b0;
		else if (overtemp_i)
			ot_hold_r <= 1'b1;
		else if (!hold_r)
			ot_hold_r <= 1'b0;
	end

	// After the reset ends outputs stay off until a re-enable event
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rearm_r <= 1'b0;
		else if (rst_cond || hold_r)
			rearm_r <= 1'b1;
		else if (clr_evt)
			rearm_r <= 1'b0;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			sync_prev_r <= 1'b0;
		else
			sync_prev_r <= lost_sync_i;
	end

	// Temperature warning and serial error are deliberately absent here
	assign disable_all = (|lat_r) || sys_lat_r || rearm_r || rst_cond || hold_r ||
		supply_uv_i || gate_regulator_uv_i || bootstrap_uv_i || vds_ov_i ||
		lost_sync_i;

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			gates_low_o <= 1'b1;
			drive_enable_o <= 1'b0;
			logic_regulator_en_o <= 1'b1;
			restart_pulse_o <= 1'b0;
			demand_o <= '0;
		end
		else
		begin
			gates_low_o <= disable_all || !run_r || demand_zero;
			// Drive enables once nothing disables, run is set and demand is nonzero
			drive_enable_o <= !disable_all && run_r && !demand_zero;
			logic_regulator_en_o <= !(overtemp_i || ot_hold_r);
			restart_pulse_o <= restart_control && lost_sync_i && !sync_prev_r;
			demand_o <= lnk.demand;
		end
	end

	assign status_v = {hold_r || rearm_r, temp_warn_i, ser_err_r, sys_lat_r, lat_r};
	assign diag_v = {2'h0, disable_all, !(overtemp_i || ot_hold_r), hold_r,
		gate_regulator_uv_i, overtemp_i, logic_regulator_uv_i};

	// Read data stand for exactly the cycle after the read
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rdata_r <= '0;
		else if (!lnk.link_rd)
			rdata_r <= '0;
		else
		begin
			unique case (lnk.link_addr)
				`MFR_LA_CTRL: rdata_r <= {ctrl_r[`MFR_DAT_W-1:1], run_r};
				`MFR_LA_STATUS: rdata_r <= status_v;
				`MFR_LA_DIAG: rdata_r <= diag_v;
				default: rdata_r <= '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			lnk.host_reset_out_n <= 1'b1;
			lnk.outputs_off <= 1'b1;
		end
		else
		begin
			lnk.host_reset_out_n <= !(rst_cond || hold_r);
			lnk.outputs_off <= disable_all;
		end
	end

	assign lnk.link_rdata = rdata_r;
endmodule
`default_nettype wire

// [mfr_params.svh]
// Constants for the motor fault response controller and its host end
`ifndef MFR_PARAMS_SVH
`define MFR_PARAMS_SVH
`define MFR_CLK_MHZ 250
`define MFR_RST_DELAY_MS 10
`define MFR_RST_CNT_W 22
`define MFR_DEM_W 8
`define MFR_DAT_W 8
`define MFR_LADDR_W 2
`define MFR_LA_CTRL 2'h0
`define MFR_LA_STATUS 2'h1
`define MFR_LA_DIAG 2'h2
`define MFR_CTRL_RUN 0
`define MFR_CTRL_RSC 1
`define MFR_CTRL_DSR 2
`define MFR_CTRL_RST 8'h00
`define MFR_NLAT 4
`define MFR_ST_SUPPLY_UV 0
`define MFR_ST_BOOT_UV 1
`define MFR_ST_VDS_OV 2
`define MFR_ST_LOST_SYNC 3
`define MFR_ST_SYS_ERR 4
`define MFR_ST_SER_ERR 5
`define MFR_ST_TEMP_WARN 6
`define MFR_ST_RST_FAULT 7
`define MFR_DG_LR_UV 0
`define MFR_DG_OT 1
`define MFR_DG_GR_UV 2
`define MFR_DG_HOLD 3
`define MFR_DG_REG_OFF 4
`define MFR_DG_OFF 5
`define MFR_SADDR_W 3
`define MFR_SA_DEMAND 3'h0
`define MFR_SA_CMD 3'h1
`define MFR_SA_WDATA 3'h2
`define MFR_SA_RDATA 3'h3
`define MFR_SA_ISTAT 3'h4
`define MFR_SA_IMASK 3'h5
`define MFR_SA_STATE 3'h6
`define MFR_CMD_RD 7
`define MFR_NEVT 3
`define MFR_EV_RST 0
`define MFR_EV_OFF 1
`define MFR_EV_RDONE 2
`endif

// [mfr_pkg.sv]
// Types used by the host end of the fault response link
`default_nettype none
package mfr_pkg;
	typedef enum logic [1:0] {HS_IDLE, HS_ISSUE, HS_CAPT} mfr_hstate_t;
	typedef logic [7:0] mfr_byte_t;
endpackage
`default_nettype wire

// [mfr_if.sv]
// Link between the host microcontroller and the fault response controller
`default_nettype none
`include "mfr_params.svh"
interface mfr_if;
	logic [`MFR_DEM_W-1:0] demand;
	logic link_wr;
	logic link_rd;
	logic [`MFR_LADDR_W-1:0] link_addr;
	logic [`MFR_DAT_W-1:0] link_wdata;
	logic [`MFR_DAT_W-1:0] link_rdata;
	logic host_reset_out_n;
	logic outputs_off;
	modport dev
	(
		input demand, link_wr, link_rd, link_addr, link_wdata,
		output link_rdata, host_reset_out_n, outputs_off
	);
	modport host
	(
		output demand, link_wr, link_rd, link_addr, link_wdata,
		input link_rdata, host_reset_out_n, outputs_off
	);
endinterface
`default_nettype wire

// [mfr_host.sv]
// Host end: software register port that drives the fault controller link
`default_nettype none
`include "mfr_params.svh"
module mfr_host
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	mfr_if.host lnk,
	input wire logic [`MFR_SADDR_W-1:0] sw_addr_i,
	input wire logic [`MFR_DAT_W-1:0] sw_wdata_i,
	input wire logic sw_wr_i,
	input wire logic sw_rd_i,
	output logic [`MFR_DAT_W-1:0] sw_rdata_o,
	output logic irq_o
);
	mfr_pkg::mfr_hstate_t state_r;
	mfr_pkg::mfr_byte_t demand_r;
	mfr_pkg::mfr_byte_t wdata_r;
	mfr_pkg::mfr_byte_t cap_r;
	logic is_rd_r;
	logic [`MFR_LADDR_W-1:0] addr_r;
	logic [`MFR_NEVT-1:0] istat_r;
	logic [`MFR_NEVT-1:0] imask_r;
	logic [`MFR_NEVT-1:0] evt;
	logic rstn_prev_r;
	logic off_prev_r;
	logic cmd_wr;

	assign cmd_wr = sw_wr_i && (sw_addr_i == `MFR_SA_CMD);

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			demand_r <= '0;
			wdata_r <= '0;
		end
		else if (sw_wr_i && (sw_addr_i == `MFR_SA_DEMAND))
			demand_r <= sw_wdata_i;
		else if (sw_wr_i && (sw_addr_i == `MFR_SA_WDATA))
			wdata_r <= sw_wdata_i;
	end

	// Commands written while busy are dropped
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_r <= mfr_pkg::HS_IDLE;
			is_rd_r <= 1'b0;
			addr_r <= '0;
			cap_r <= '0;
		end
		else
		begin
			unique case (state_r)
				mfr_pkg::HS_IDLE:
					if (cmd_wr)
					begin
						state_r <= mfr_pkg::HS_ISSUE;
						is_rd_r <= sw_wdata_i[`MFR_CMD_RD];
						addr_r <= sw_wdata_i[`MFR_LADDR_W-1:0];
					end
				mfr_pkg::HS_ISSUE:
					state_r <= is_rd_r ? mfr_pkg::HS_CAPT : mfr_pkg::HS_IDLE;
				mfr_pkg::HS_CAPT:
				begin
					cap_r <= lnk.link_rdata;
					state_r <= mfr_pkg::HS_IDLE;
				end
			endcase
		end
	end

	assign lnk.demand = demand_r;
	assign lnk.link_addr = addr_r;
	assign lnk.link_wdata = wdata_r;
	assign lnk.link_wr = (state_r == mfr_pkg::HS_ISSUE) && !is_rd_r;
	assign lnk.link_rd = (state_r == mfr_pkg::HS_ISSUE) && is_rd_r;

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rstn_prev_r <= 1'b1;
			off_prev_r <= 1'b1;
		end
		else
		begin
			rstn_prev_r <= lnk.host_reset_out_n;
			off_prev_r <= lnk.outputs_off;
		end
	end

	assign evt[`MFR_EV_RST] = rstn_prev_r && !lnk.host_reset_out_n;
	assign evt[`MFR_EV_OFF] = !off_prev_r && lnk.outputs_off;
	assign evt[`MFR_EV_RDONE] = (state_r == mfr_pkg::HS_CAPT);

	// New events win over a write-one clear in the same cycle
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			istat_r <= '0;
		else if (sw_wr_i && (sw_addr_i == `MFR_SA_ISTAT))
			istat_r <= (istat_r & ~sw_wdata_i[`MFR_NEVT-1:0]) | evt;
		else
			istat_r <= istat_r | evt;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			imask_r <= '0;
		else if (sw_wr_i && (sw_addr_i == `MFR_SA_IMASK))
			imask_r <= sw_wdata_i[`MFR_NEVT-1:0];
	end

	assign irq_o = |(istat_r & imask_r);

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			sw_rdata_o <= '0;
		else if (!sw_rd_i)
			sw_rdata_o <= '0;
		else
		begin
			unique case (sw_addr_i)
				`MFR_SA_DEMAND: sw_rdata_o <= demand_r;
				`MFR_SA_WDATA: sw_rdata_o <= wdata_r;
				`MFR_SA_RDATA: sw_rdata_o <= cap_r;
				`MFR_SA_ISTAT: sw_rdata_o <= {5'h00, istat_r};
				`MFR_SA_IMASK: sw_rdata_o <= {5'h00, imask_r};
				`MFR_SA_STATE: sw_rdata_o <= {5'h00, (state_r != mfr_pkg::HS_IDLE),
					lnk.outputs_off, lnk.host_reset_out_n};
				default: sw_rdata_o <= '0;
			endcase
		end
	end
endmodule
`default_nettype wire

// [mfr_link_monitor.sv]
// Checker on the link between host end and fault controller
`default_nettype none
`include "mfr_params.svh"
module mfr_link_monitor
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic [`MFR_DEM_W-1:0] demand,
	input wire logic link_wr,
	input wire logic link_rd,
	input wire logic [`MFR_LADDR_W-1:0] link_addr,
	input wire logic [`MFR_DAT_W-1:0] link_wdata,
	input wire logic [`MFR_DAT_W-1:0] link_rdata,
	input wire logic host_reset_out_n,
	input wire logic outputs_off
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);
	chk_rdata_slot_only: assert property (!$past(link_rd) |-> link_rdata == 8'h00)
		else $error("read data outside its slot");
	chk_one_strobe: assert property (!(link_wr && link_rd))
		else $error("write and read together");
	chk_rd_single_pulse: assert property (link_rd |=> !link_rd)
		else $error("read strobe too long");
	chk_wr_single_pulse: assert property (link_wr |=> !link_wr)
		else $error("write strobe too long");
	chk_reset_disables: assert property (!host_reset_out_n |-> outputs_off)
		else $error("host reset without disable");
	chk_reset_hold: assert property ($fell(host_reset_out_n) |=> !host_reset_out_n [*8])
		else $error("host reset released too soon");
	chk_unmapped_zero: assert property (
		$past(link_rd && link_addr == 2'h3) |-> link_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_diag_spare: assert property (
		$past(link_rd && link_addr == `MFR_LA_DIAG) |-> link_rdata[7:6] == 2'h0)
		else $error("spare diagnostic bits set");
	cover property ($fell(host_reset_out_n));
	cover property (link_rd && link_addr == `MFR_LA_STATUS);
	cover property (demand == 8'h00 ##1 demand != 8'h00);
	cover property (link_wr && link_wdata[`MFR_CTRL_RUN] && $rose(outputs_off) == 1'b0);
endmodule
`default_nettype wire

// [motor_fault_response_ctrl_bench.sv]
// Self-checking bench for both ends of the fault response link
`default_nettype none
`include "mfr_params.svh"
module motor_fault_response_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [9:0] f = '0;
	logic [2:0] sa = '0;
	logic [7:0] sd = '0;
	logic sw_w = 1'b0;
	logic sw_r = 1'b0;
	logic [7:0] rd;
	logic [7:0] dmo;
	logic irq, gl, de, lre, rp;
	int fails = 0;
	int compares = 0;
	int pulses = 0;
	mfr_if lnk();
	// Fault vector low bits follow the status layout
	mfr_dev #(.RST_HOLD_CYC(20)) i_mfr_dev (.sys_clk_i(clk), .rstn_i(rstn), .lnk(lnk),
		.supply_uv_i(f[0]), .bootstrap_uv_i(f[1]), .vds_ov_i(f[2]), .lost_sync_i(f[3]),
		.system_err_i(f[4]), .serial_err_i(f[5]), .temp_warn_i(f[6]),
		.logic_regulator_uv_i(f[7]), .overtemp_i(f[8]), .gate_regulator_uv_i(f[9]),
		.gates_low_o(gl), .drive_enable_o(de), .logic_regulator_en_o(lre),
		.restart_pulse_o(rp), .demand_o(dmo));
	mfr_host i_mfr_host (.sys_clk_i(clk), .rstn_i(rstn), .lnk(lnk), .sw_addr_i(sa),
		.sw_wdata_i(sd), .sw_wr_i(sw_w), .sw_rd_i(sw_r), .sw_rdata_o(rd), .irq_o(irq));
	mfr_link_monitor i_mfr_link_monitor (.sys_clk_i(clk), .rstn_i(rstn),
		.demand(lnk.demand), .link_wr(lnk.link_wr), .link_rd(lnk.link_rd),
		.link_addr(lnk.link_addr), .link_wdata(lnk.link_wdata), .link_rdata(lnk.link_rdata),
		.host_reset_out_n(lnk.host_reset_out_n), .outputs_off(lnk.outputs_off));
	initial
	begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		if (rp === 1'b1)
			pulses++;
	end
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic results();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic swr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		sa <= a;
		sd <= d;
		sw_w <= 1'b1;
		@(posedge clk);
		sw_w <= 1'b0;
	endtask
	task automatic srd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		sa <= a;
		sw_r <= 1'b1;
		@(posedge clk);
		sw_r <= 1'b0;
		#1;
		d = rd;
	endtask
	// Link write to the control byte; CMD refuses while busy, so wait it out
	task automatic lwr(input logic [7:0] d);
		swr(`MFR_SA_WDATA, d);
		swr(`MFR_SA_CMD, 8'h00);
		tick(3);
	endtask
	task automatic lrd(input logic [1:0] a, output logic [7:0] d);
		swr(`MFR_SA_CMD, {6'h20, a});
		tick(4);
		srd(`MFR_SA_RDATA, d);
	endtask
	task automatic fault(input int i, input int n);
		@(posedge clk);
		f[i] <= 1'b1;
		repeat (n) @(posedge clk);
		f[i] <= 1'b0;
		tick(3);
	endtask
	function automatic logic [7:0] stb(input int i);
		return 8'h01 << i;
	endfunction
	function automatic logic [7:0] on_exp(input logic run, input logic [7:0] dm);
		return {7'h0, run && dm != 8'h00};
	endfunction
	initial
	begin
		logic [7:0] d;
		logic [7:0] dm;
		int i;
		int n;
		d = 8'($urandom(32'h98c6));
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		tick(2);
		chk("gates_low", {7'h0, gl}, 8'h01);
		chk("reg_en", {7'h0, lre}, 8'h01);
		chk("rst_n", {7'h0, lnk.host_reset_out_n}, 8'h01);
		srd(3'h7, d);
		chk("sw_unmapped", d, 8'h00);
		lrd(2'h3, d);
		chk("link_unmapped", d, 8'h00);
		dm = 8'($urandom_range(255, 1));
		swr(`MFR_SA_DEMAND, dm);
		lwr(8'h01);
		chk("demand_o", dmo, dm);
		chk("enable", {7'h0, de}, on_exp(1'b1, dm));
		srd(`MFR_SA_STATE, d);
		chk("host_state", d, 8'h01);
		srd(`MFR_SA_DEMAND, d);
		chk("demand_reg", d, dm);
		srd(`MFR_SA_WDATA, d);
		chk("wdata_reg", d, 8'h01);
		lrd(`MFR_LA_CTRL, d);
		chk("ctrl_read", d, 8'h01);
		$display("test reset done");
		for (i = 0; i < 4; i++)
		begin
			fault(i, 1);
			chk("latched_off", {7'h0, gl}, 8'h01);
			lrd(`MFR_LA_STATUS, d);
			chk("status", d, stb(i));
			tick(2);
			chk("read_clear", {7'h0, de}, 8'h01);
		end
		lwr(8'h05);
		fault(2, 2);
		lrd(`MFR_LA_STATUS, d);
		tick(2);
		chk("dsr_hold", {7'h0, gl}, 8'h01);
		swr(`MFR_SA_DEMAND, 8'h00);
		tick(2);
		dm = 8'($urandom_range(255, 1));
		swr(`MFR_SA_DEMAND, dm);
		tick(3);
		chk("demand_clear", {7'h0, de}, on_exp(1'b1, dm));
		fault(1, 1);
		lwr(8'h04);
		lwr(8'h05);
		chk("run_clear", {7'h0, de}, 8'h01);
		$display("test latch done");
		lwr(8'h03);
		@(posedge clk);
		f[0] <= 1'b1;
		tick(3);
		chk("uv_off", {7'h0, gl}, 8'h01);
		@(posedge clk);
		f[0] <= 1'b0;
		tick(3);
		chk("uv_self_clear", {7'h0, de}, 8'h01);
		n = pulses;
		fault(3, 2);
		chk("restart", 8'(pulses - n), 8'h01);
		chk("sync_no_latch", {7'h0, de}, 8'h01);
		@(posedge clk);
		f[6:5] <= 2'b11;
		tick(3);
		chk("warn_on", {7'h0, de}, 8'h01);
		lrd(`MFR_LA_STATUS, d);
		chk("warn_status", d, stb(5) | stb(6));
		@(posedge clk);
		f[6:5] <= 2'b00;
		tick(3);
		// Serial error stays until a read after the condition ends
		lrd(`MFR_LA_STATUS, d);
		chk("warn_clear", d, stb(5));
		lrd(`MFR_LA_STATUS, d);
		chk("ser_err_clear", d, 8'h00);
		fault(4, 1);
		chk("syserr_off", {7'h0, gl}, 8'h01);
		lwr(8'h03);
		chk("syserr_rerun", {7'h0, de}, 8'h01);
		$display("test restart done");
		for (i = 0; i < 2; i++)
		begin
			swr(`MFR_SA_ISTAT, 8'hff);
			swr(`MFR_SA_IMASK, 8'h01);
			@(posedge clk);
			f[7 + i] <= 1'b1;
			tick(3);
			chk("rst_low", {7'h0, lnk.host_reset_out_n}, 8'h00);
			chk("reg_state", {7'h0, lre}, i == 0 ? 8'h01 : 8'h00);
			chk("irq", {7'h0, irq}, 8'h01);
			srd(`MFR_SA_ISTAT, d);
			chk("istat", d, 8'h03);
			srd(`MFR_SA_IMASK, d);
			chk("imask", d, 8'h01);
			lrd(`MFR_LA_DIAG, d);
			chk("diag", d & 8'h23, i == 0 ? 8'h21 : 8'h22);
			@(posedge clk);
			f[7 + i] <= 1'b0;
			n = 0;
			while (lnk.host_reset_out_n !== 1'b1 && n < 200)
			begin
				@(posedge clk);
				n++;
			end
			// A stuck reset line must not hang the run
			if (n == 200)
			begin
				fails++;
				results();
			end
			chk("hold_len", {7'h0, n >= 20 && n <= 24}, 8'h01);
			tick(2);
			chk("rearm_off", {7'h0, gl}, 8'h01);
			lwr(8'h02);
			lwr(8'h03);
			chk("rearm_run", {7'h0, de}, 8'h01);
			swr(`MFR_SA_IMASK, 8'h00);
			tick(1);
			chk("irq_masked", {7'h0, irq}, 8'h00);
			swr(`MFR_SA_ISTAT, 8'h07);
			swr(`MFR_SA_IMASK, 8'h01);
			tick(1);
			chk("irq_cleared", {7'h0, irq}, 8'h00);
		end
		$display("test host reset done");
		results();
	end
endmodule
`default_nettype wire
